// ---- hdl/smt_defines.svh ----
// Offsets, field positions, reset values and the implemented-bit mask for the static memory timing block.
// Assumes inclusion by bare name from the design module.
`ifndef SMT_DEFINES_SVH
`define SMT_DEFINES_SVH

// ********************
// Register map
// ********************
`define SMT_SET0_OFS 8'h00
`define SMT_SET1_OFS 8'h04
`define SMT_SET2_OFS 8'h08
`define SMT_STAT_OFS 8'h0c
`define SMT_CMD_OFS 8'h10

// ********************
// Field positions
// ********************
`define SMT_RDY_BIT 26
`define SMT_PSZ_LSB 24
`define SMT_PMODE_BIT 23
`define SMT_PAGE_READ_CYCLES_LSB 19
`define SMT_TURNAROUND_CYCLES_LSB 16
`define SMT_TWP_LSB 10
`define SMT_TWR_LSB 8
`define SMT_TAS_LSB 6
`define SMT_TRC_LSB 0
`define SMT_IMPL_MASK 32'h07ff_ffff

// ********************
// Reset value
// ********************
`define SMT_RESET_VAL 32'h041c_2d4b

`endif

// ---- hdl/smt_pkg.sv ----
// Types shared by the static memory timing block.
// Assumes the defines header sits in the include path.
package smt_pkg;

   typedef struct packed {
      logic use_ready_input;
      logic [1:0] page_length_sel;
      logic page_read_support;
      logic [3:0] page_read_cycles;
      logic [2:0] turnaround_cycles;
      logic [5:0] write_pulse_cycles;
      logic [1:0] write_hold_cycles;
      logic [1:0] addr_setup_cycles;
      logic [5:0] read_cycle_cycles;
   } timing_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [1:0] cs;
      logic page;
   } mem_req_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_TURN,
      ST_SETUP,
      ST_READ,
      ST_WPULSE,
      ST_WHOLD
   } mem_state_t;

endpackage

// ---- hdl/static_memory_timing_config.sv ----
// Three static memory timing sets on classic Wishbone plus a cycle sequencer.
// Assumes one 20 MHz clock; memory requests and ready input are synchronous to it.
`timescale 1ns/1ps
`include "smt_defines.svh"

module static_memory_timing_config
   import smt_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire mem_req_t mreq_i,
   input wire logic [2:0] external_ready_in_i,
   output logic mem_busy_o,
   output logic mem_done_o,
   output logic [2:0] cs_n_o,
   output logic we_n_o,
   output logic oe_n_o,
   output logic [5:0] page_words_o
);

   // ********************
   // Register bus
   // ********************
   logic [2:0][31:0] set_q;
   logic ack_q;
   logic [31:0] rdat_q;
   wire bus_req = cyc_i && stb_i && !ack_q;
   // Write lands at the edge where the master samples ack, with the request still up
   wire wr_en = cyc_i && stb_i && we_i && ack_q;
   wire [31:0] bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   wire hit0 = (adr_i == `SMT_SET0_OFS);
   wire hit1 = (adr_i == `SMT_SET1_OFS);
   wire hit2 = (adr_i == `SMT_SET2_OFS);
   wire hit_stat = (adr_i == `SMT_STAT_OFS);
   wire [2:0] set_hit = {hit2, hit1, hit0};
   logic [31:0] rsel;
   mem_state_t state_q;
   logic [1:0] cs_q;
   logic last_rd_q;

   always_comb
   begin
      if (hit0) rsel = set_q[0];
      else if (hit1) rsel = set_q[1];
      else if (hit2) rsel = set_q[2];
      else if (hit_stat) rsel = {26'h0, last_rd_q, cs_q, state_q};
      else rsel = 32'h0;
   end

   // Unmapped addresses still ack with zero so a stray access never hangs the bus
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_set
         always_ff @(posedge mclk_i or posedge rst_i)
         begin
            if (rst_i)
               set_q[g] <= `SMT_RESET_VAL;
            else if (wr_en && set_hit[g])
               set_q[g] <= ((set_q[g] & ~bmask) | (dat_i & bmask)) & `SMT_IMPL_MASK;
         end
      end
   endgenerate

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
      end
      else
      begin
         ack_q <= bus_req;
         rdat_q <= rsel;
      end
   end
   assign ack_o = ack_q;
   assign dat_o = rdat_q;

   // ********************
   // Memory cycle sequencer
   // ********************
   timing_t tsel;
   assign tsel = timing_t'(set_q[mreq_i.cs][26:0]);
   timing_t t_q;
   logic [6:0] cnt_q;
   logic we_q;
   logic page_q;
   logic started_q;
   wire rdy_ok = !t_q.use_ready_input || external_ready_in_i[cs_q];
   wire cnt_zero = (cnt_q == 7'h0);
   wire cs_change = started_q && (mreq_i.cs != cs_q);
   // read-to-read, read-to-write and write-to-read all start from a read or write
   wire need_turn = cs_change && (last_rd_q || mreq_i.we != we_q);
   wire use_page = mreq_i.page && tsel.page_read_support && !mreq_i.we;
   // The done pulse still stands while the requester drops req, so it blocks a repeat take
   wire mem_take = mreq_i.req && (mreq_i.cs != 2'h3) && !mem_done_o;
   wire [6:0] rd_len = use_page ? {3'h0, tsel.page_read_cycles}
                                : {1'b0, tsel.read_cycle_cycles};

   always_comb
   begin
      case (t_q.page_length_sel)
         2'h0: page_words_o = 6'h04;
         2'h1: page_words_o = 6'h08;
         2'h2: page_words_o = 6'h10;
         default: page_words_o = 6'h20;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 7'h0;
         t_q <= timing_t'(27'h0);
         cs_q <= 2'h0;
         we_q <= 1'b0;
         page_q <= 1'b0;
         last_rd_q <= 1'b0;
         started_q <= 1'b0;
         mem_done_o <= 1'b0;
      end
      else
      begin
         mem_done_o <= 1'b0;
         case (state_q)
            ST_IDLE:
               if (mem_take)
               begin
                  t_q <= tsel;
                  we_q <= mreq_i.we;
                  page_q <= use_page;
                  if (need_turn && tsel.turnaround_cycles != 3'h0)
                  begin
                     state_q <= ST_TURN;
                     cnt_q <= {4'h0, tsel.turnaround_cycles} - 7'h1;
                  end
                  else if (mreq_i.we && tsel.addr_setup_cycles != 2'h0)
                  begin
                     state_q <= ST_SETUP;
                     cnt_q <= {5'h0, tsel.addr_setup_cycles} - 7'h1;
                  end
                  else if (mreq_i.we)
                  begin
                     state_q <= ST_WPULSE;
                     cnt_q <= {1'b0, tsel.write_pulse_cycles};
                  end
                  else
                  begin
                     state_q <= ST_READ;
                     cnt_q <= rd_len;
                  end
                  cs_q <= mreq_i.cs;
                  started_q <= 1'b1;
               end
            ST_TURN:
               if (cnt_zero)
               begin
                  if (we_q && t_q.addr_setup_cycles != 2'h0)
                  begin
                     state_q <= ST_SETUP;
                     cnt_q <= {5'h0, t_q.addr_setup_cycles} - 7'h1;
                  end
                  else if (we_q)
                  begin
                     state_q <= ST_WPULSE;
                     cnt_q <= {1'b0, t_q.write_pulse_cycles};
                  end
                  else
                  begin
                     state_q <= ST_READ;
                     cnt_q <= page_q ? {3'h0, t_q.page_read_cycles}
                                     : {1'b0, t_q.read_cycle_cycles};
                  end
               end
               else
                  cnt_q <= cnt_q - 7'h1;
            ST_SETUP:
               if (cnt_zero)
               begin
                  state_q <= ST_WPULSE;
                  cnt_q <= {1'b0, t_q.write_pulse_cycles};
               end
               else
                  cnt_q <= cnt_q - 7'h1;
            ST_READ:
               if (cnt_zero && rdy_ok)
               begin
                  state_q <= ST_IDLE;
                  last_rd_q <= 1'b1;
                  mem_done_o <= 1'b1;
               end
               else if (!cnt_zero)
                  cnt_q <= cnt_q - 7'h1;
            ST_WPULSE:
               if (cnt_zero && rdy_ok)
               begin
                  last_rd_q <= 1'b0;
                  if (t_q.write_hold_cycles != 2'h0)
                  begin
                     state_q <= ST_WHOLD;
                     cnt_q <= {5'h0, t_q.write_hold_cycles} - 7'h1;
                  end
                  else
                  begin
                     state_q <= ST_IDLE;
                     mem_done_o <= 1'b1;
                  end
               end
               else if (!cnt_zero)
                  cnt_q <= cnt_q - 7'h1;
            ST_WHOLD:
               if (cnt_zero)
               begin
                  state_q <= ST_IDLE;
                  mem_done_o <= 1'b1;
               end
               else
                  cnt_q <= cnt_q - 7'h1;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Strobes decode from state so they change together with the state flop
   wire active = (state_q != ST_IDLE) && (state_q != ST_TURN);
   assign mem_busy_o = (state_q != ST_IDLE);
   assign we_n_o = !(state_q == ST_WPULSE);
   assign oe_n_o = !(state_q == ST_READ);
   assign cs_n_o = active ? ~(3'h1 << cs_q) : 3'h7;

   // ********************
   // Checks
   // ********************
   logic [7:0] wp_len_q;
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i) wp_len_q <= 8'h0;
      else if (state_q == ST_WPULSE) wp_len_q <= wp_len_q + 8'h1;
      else wp_len_q <= 8'h0;
   end

   AST_WPULSE_LEN: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_WPULSE && state_q != $past(state_q) && !t_q.use_ready_input)
      |-> !we_n_o[*1] ##0 (wp_len_q == 8'h0))
      else $error("write pulse start wrong");
   AST_WPULSE_END: assert property (@(posedge mclk_i) disable iff (rst_i)
      ($rose(we_n_o) && !t_q.use_ready_input)
      |-> (wp_len_q == {2'h0, t_q.write_pulse_cycles} + 8'h1)
          && ($past(wp_len_q) == {2'h0, t_q.write_pulse_cycles}))
      else $error("write pulse length wrong");
   AST_RSV_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
      (set_q[0][31:27] == 5'h0) && (set_q[1][31:27] == 5'h0) && (set_q[2][31:27] == 5'h0))
      else $error("reserved bits set");
   AST_ACK_ONE: assert property (@(posedge mclk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
      else $error("ack timing wrong");
   AST_RDY_WAIT: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_READ && cnt_zero && t_q.use_ready_input && !external_ready_in_i[cs_q])
      |=> state_q == ST_READ)
      else $error("ready ignored");
   AST_NO_PAGE: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_IDLE && mem_take && !tsel.page_read_support
       && !need_turn && !mreq_i.we) |=> cnt_q == {1'b0, t_q.read_cycle_cycles})
      else $error("page read without support");
   AST_PAGE_SIZE: assert property (@(posedge mclk_i) disable iff (rst_i)
      page_words_o == (6'h04 << t_q.page_length_sel))
      else $error("page size wrong");
   AST_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_WHOLD && $past(state_q) == ST_WPULSE && t_q.write_hold_cycles == 2'h2)
      |-> (!cs_n_o[cs_q] && we_n_o)[*2] ##1 mem_done_o)
      else $error("write hold wrong");
   AST_TURN: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_TURN && $past(state_q) == ST_IDLE && t_q.turnaround_cycles == 3'h3)
      |-> (cs_n_o == 3'h7)[*3] ##1 (state_q != ST_TURN))
      else $error("turnaround wrong");

   // Read length is counted in helper logic rather than by a long repetition
   logic [7:0] rd_cnt_q;
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i) rd_cnt_q <= 8'h0;
      else if (state_q == ST_READ) rd_cnt_q <= rd_cnt_q + 8'h1;
      else rd_cnt_q <= 8'h0;
   end

   AST_READ_LEN: assert property (@(posedge mclk_i) disable iff (rst_i)
      ($rose(oe_n_o) && !t_q.use_ready_input && !page_q)
      |-> rd_cnt_q == {2'h0, t_q.read_cycle_cycles} + 8'h1)
      else $error("read cycle length wrong");
   AST_PAGE_LEN: assert property (@(posedge mclk_i) disable iff (rst_i)
      ($rose(oe_n_o) && !t_q.use_ready_input && page_q)
      |-> rd_cnt_q == {4'h0, t_q.page_read_cycles} + 8'h1)
      else $error("page read length wrong");
   AST_READ_STROBES: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_READ) |-> (we_n_o && !oe_n_o && !cs_n_o[cs_q]))
      else $error("read strobes wrong");
   AST_RDY_IGNORED: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_READ && cnt_zero && !t_q.use_ready_input) |=> state_q == ST_IDLE)
      else $error("ready not ignored");
   AST_SETUP_ONE: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_SETUP && $past(state_q) != ST_SETUP && t_q.addr_setup_cycles == 2'h1)
      |=> state_q == ST_WPULSE)
      else $error("address setup length wrong");
   AST_SETUP_STROBES: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_SETUP) |-> (!cs_n_o[cs_q] && we_n_o && oe_n_o))
      else $error("address setup strobes wrong");
   AST_WHOLD_ONE: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_WHOLD && $past(state_q) == ST_WPULSE && t_q.write_hold_cycles == 2'h1)
      |-> !cs_n_o[cs_q] ##1 (state_q == ST_IDLE && mem_done_o))
      else $error("single hold wrong");
   AST_ZERO_TURN: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_IDLE && mem_take && tsel.turnaround_cycles == 3'h0)
      |=> state_q != ST_TURN)
      else $error("turnaround without cycles");
   AST_TURN_BUS: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_q == ST_TURN) |-> (cs_n_o == 3'h7 && we_n_o && oe_n_o))
      else $error("bus not idle in turnaround");
   AST_ONE_CS: assert property (@(posedge mclk_i) disable iff (rst_i)
      $onehot0(~cs_n_o))
      else $error("more than one select");

endmodule

// ---- bench/smt_mem_model.sv ----
// Far-side memory model: drives the per-set ready inputs.
// Assumes chip selects are active low and synchronous to mclk_i.
`timescale 1ns/1ps

// ****************
// Ready model
// ****************
// Ready rises DLY clocks after its select falls, only where RDY_EN has a 1,
// so a set that wrongly waits on ready hangs and times out.
module smt_mem_model #(
   parameter int DLY = 6,
   parameter logic [2:0] RDY_EN = 3'h2
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [2:0] cs_n_i,
   output logic [2:0] ready_o
);
   int cnt [3];

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (rst_i || cs_n_i[i])
            cnt[i] <= 0;
         else if (cnt[i] < DLY)
            cnt[i] <= cnt[i] + 1;
      end
   end

   always_comb
   begin
      for (int i = 0; i < 3; i++)
         ready_o[i] = RDY_EN[i] && (cnt[i] >= DLY);
   end
endmodule

// ---- bench/static_memory_timing_config_tb_top.sv ----
// Testbench for the static memory timing block.
// Assumes the package is compiled first; Wishbone acks within 50 clocks.
`timescale 1ns/1ps

module static_memory_timing_config_tb_top;
   import smt_pkg::*;
   logic mclk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
   logic mem_busy_o, mem_done_o, we_n_o, oe_n_o;
   logic [7:0] adr_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [3:0] sel_i;
   mem_req_t mreq_i;
   logic [2:0] ext_rdy, cs_n_o;
   logic [5:0] page_words_o;
   int fail_count, compares, n_oe, n_we, n_cs, n_gap;

   static_memory_timing_config u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
      .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
      .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .mreq_i(mreq_i), .external_ready_in_i(ext_rdy),
      .mem_busy_o(mem_busy_o), .mem_done_o(mem_done_o), .cs_n_o(cs_n_o),
      .we_n_o(we_n_o), .oe_n_o(oe_n_o), .page_words_o(page_words_o));

   smt_mem_model u_mem (.mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n_o),
      .ready_o(ext_rdy));

   // ****************
   // Tasks
   // ****************
   task end_sim;
      $display("mismatches %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // Classic cycle; released only at the edge that samples ack
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      for (i = 0; i < 50; i++)
      begin
         @(posedge mclk_i);
         if (ack_o === 1'b1)
            break;
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (i == 50)
      begin
         fail_count++;
         end_sim;
      end
   endtask

   task wset(input logic [7:0] a, input timing_t t);
      wb(1'b1, a, {5'h00, t});
   endtask

   // Memory cycle; counts strobe, select and turnaround clocks
   task mop(input logic w, input logic [1:0] c, input logic p);
      int i;
      n_oe = 0;
      n_we = 0;
      n_cs = 0;
      n_gap = 0;
      @(posedge mclk_i);
      mreq_i <= '{req: 1'b1, we: w, cs: c, page: p};
      for (i = 0; i < 400; i++)
      begin
         @(posedge mclk_i);
         n_oe += int'(oe_n_o === 1'b0);
         n_we += int'(we_n_o === 1'b0);
         n_cs += int'(cs_n_o[c] === 1'b0);
         n_gap += int'(mem_busy_o === 1'b1 && cs_n_o === 3'h7);
         if (mem_done_o === 1'b1)
            break;
      end
      mreq_i.req <= 1'b0;
      if (i == 400)
      begin
         fail_count++;
         end_sim;
      end
   endtask

   initial
   begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   // ****************
   // Scenarios
   // ****************
   initial
   begin
      {rst_i, cyc_i, stb_i, we_i} = 4'h8;
      adr_i = 8'h00;
      dat_i = 32'h0;
      sel_i = 4'hf;
      mreq_i = '0;
      fail_count = 0;
      compares = 0;
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         wb(1'b0, 8'(k * 4), 32'h0);
         chk(rd, 32'h041c_2d4b);
      end
      wb(1'b1, 8'h04, 32'hffff_ffff);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h07ff_ffff);
      wb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h041c_2d4b);
      wb(1'b1, 8'h1c, 32'hffff_ffff);
      wb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h0);
      // Setup of one clock: these parts are not synchronous SRAM
      wset(8'h00, '{1'b0, 2'h0, 1'b0, 4'h0, 3'h0, 6'h02, 2'h1, 2'h1, 6'h02});
      wset(8'h04, '{1'b1, 2'h0, 1'b0, 4'h0, 3'h0, 6'h02, 2'h1, 2'h1, 6'h01});
      wset(8'h08, '{1'b0, 2'h0, 1'b0, 4'h3, 3'h5, 6'h02, 2'h1, 2'h1, 6'h00});
      mop(1'b0, 2'h0, 1'b0);
      chk(n_oe, 3);
      mop(1'b1, 2'h0, 1'b0);
      chk(n_we, 3);
      chk(n_cs, 5);
      mop(1'b0, 2'h0, 1'b0);
      chk(n_oe, 3);
      mop(1'b0, 2'h2, 1'b0);
      chk(n_gap, 5);
      mop(1'b0, 2'h2, 1'b1);
      chk(n_oe, 1);
      for (int ps = 0; ps < 4; ps++)
      begin
         wset(8'h08, '{1'b0, 2'(ps), 1'b1, 4'h3, 3'h5, 6'h02, 2'h1, 2'h1, 6'h00});
         mop(1'b0, 2'h2, 1'b1);
         chk(n_oe, 4);
         chk(32'(page_words_o), 32'(4 << ps));
      end
      // Write after a read on another select: turnaround, then a two-clock hold
      wset(8'h00, '{1'b0, 2'h0, 1'b0, 4'h0, 3'h3, 6'h02, 2'h2, 2'h1, 6'h02});
      mop(1'b1, 2'h0, 1'b0);
      chk(n_gap, 3);
      chk(n_we, 3);
      chk(n_cs, 6);
      // Late ready stretches the set-1 read past its two counted clocks
      mop(1'b0, 2'h1, 1'b0);
      chk(32'(n_oe >= 6), 32'h1);
      wb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0000_0028);
      end_sim;
   end
endmodule
